// ### core/cdcfg_regs.sv
// cdcfg_regs: apb register bank configuring the codec dsp clocking,
// serial formats, memory partitions, accelerator and jump pins.
// assumes one pclk domain; outputs feed the dsp core and pin muxes.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module cdcfg_regs
  import cdcfg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [2:0]  sample_rate_code,  // from clock setting one
  input  wire logic        system_reset_n,    // codec/dsp reset level
  input  wire logic        pin14_sdout3_en,   // serial out 3 enable
  input  wire logic        pin15_sdout2_en,   // serial out 2 enable
  output cdcfg_clk_t       clk_cfg,
  output cdcfg_fmt_bus_t   fmt_cfg,
  output cdcfg_mem_t       mem_cfg,
  output cdcfg_jump_t      jump_cfg,
  output logic             accel_clr_we,      // zero write strobe
  output logic [10:0]      accel_clr_addr
);

  cdcfg_state_t st_r;          // registered state
  cdcfg_state_t st_nxt;        // next state
  logic         wr_en;         // write taken this cycle
  logic         rd_en;         // read taken this cycle
  logic [7:0]   idx;           // word index of the access
  logic         hit;           // index is mapped
  logic [7:0]   rd_byte;       // byte returned
  logic [7:0]   wb;            // write byte lane 0

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_en  = psel & penable & pwrite;
  assign rd_en  = psel & penable & ~pwrite;
  assign idx    = paddr[9:2];
  assign wb     = pwdata[7:0];
  assign hit    = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
                  (idx >= CDCFG_IDX_CLK2) && (idx <= CDCFG_IDX_STAT);

  // read mux over the stored bytes and the decode status word
  always_comb begin
    case (idx)
      CDCFG_IDX_CLK2: rd_byte = st_r.clk2;
      CDCFG_IDX_SFMT: rd_byte = st_r.sfmt;
      CDCFG_IDX_DLYF: rd_byte = st_r.dlyf;
      CDCFG_IDX_DRAM: rd_byte = st_r.dram;
      CDCFG_IDX_ACCL: rd_byte = st_r.accl;
      CDCFG_IDX_DEMF: rd_byte = st_r.demf;
      CDCFG_IDX_DOUT: rd_byte = st_r.dout;
      // busy, three invalid-code flags, then the irregular bit clock flag
      CDCFG_IDX_STAT: rd_byte = {3'h0, st_r.clr_busy,
                                 fmt_cfg.tdm_source_bad,
                                 mem_cfg.dram_size_bad,
                                 mem_cfg.dly_bank_bad,
                                 clk_cfg.bitclk_irregular};
      default:        rd_byte = 8'h00;
    endcase
  end

  // next state: register writes, zero-fill sweep, read data
  always_comb begin
    st_nxt = st_r;
    st_nxt.ckrst_d = st_r.clk2[CDCFG_P_CKRN];
    // writes land only with lane 0 strobed; status word is read only
    if (wr_en && hit && pstrb[0]) begin
      case (idx)
        CDCFG_IDX_CLK2: st_nxt.clk2 = wb;
        CDCFG_IDX_SFMT: st_nxt.sfmt = wb;
        CDCFG_IDX_DLYF: st_nxt.dlyf = wb;
        CDCFG_IDX_DRAM: st_nxt.dram = wb & CDCFG_MASK_DRAM;
        CDCFG_IDX_ACCL: st_nxt.accl = wb;
        CDCFG_IDX_DEMF: st_nxt.demf = wb & CDCFG_MASK_DEMF;
        CDCFG_IDX_DOUT: st_nxt.dout = wb & CDCFG_MASK_DOUT;
        default:        st_nxt.clk2 = st_r.clk2;
      endcase
    end
    // zero fill of the accelerator coefficient ram on reset release
    if (st_r.clr_busy) begin
      if (st_r.clr_addr == CDCFG_ACC_WORDS) begin
        st_nxt.clr_busy = 1'b0;
      end else begin
        st_nxt.clr_addr = st_r.clr_addr + 11'h001;
      end
    end else if (st_r.clk2[CDCFG_P_CKRN] && !st_r.ckrst_d &&
                 !st_r.accl[CDCFG_P_ACLR]) begin
      st_nxt.clr_busy = 1'b1;
      st_nxt.clr_addr = 11'h000;
    end
    // read data not registered; the state copies stay zero and the
    // combinational zero-wait answer below returns it in the access cycle
    st_nxt.prdata  = 32'h0000_0000;
    st_nxt.pslverr = 1'b0;
  end

  // unmapped or misaligned access answers with an error
  assign pslverr = psel & penable & ~hit;
  assign prdata  = (rd_en && hit) ? {24'h000000, rd_byte} : 32'h0000_0000;

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign accel_clr_we   = st_r.clr_busy;
  assign accel_clr_addr = st_r.clr_addr;

  // clock generator decode
  always_comb begin
    clk_cfg = '0;
    clk_cfg.clock_reset_n    = st_r.clk2[CDCFG_P_CKRN];
    clk_cfg.tdm_enable       = st_r.sfmt[CDCFG_P_TDM];
    clk_cfg.bitclk_ratio_sel =
      cdcfg_ratio_t'(st_r.clk2[CDCFG_P_RATIO +: 2]);
    case (clk_cfg.bitclk_ratio_sel)
      CDCFG_R64: clk_cfg.bitclk_per_frame = 9'd64;
      CDCFG_R48: clk_cfg.bitclk_per_frame = 9'd48;
      CDCFG_R32: clk_cfg.bitclk_per_frame = 9'd32;
      default:   clk_cfg.bitclk_per_frame = 9'd256;
    endcase
    if (clk_cfg.tdm_enable) begin
      clk_cfg.bitclk_per_frame = 9'd256;
    end
    // odd rates (12/24/48/96k codes 1,3,5,6) do not divide evenly
    clk_cfg.bitclk_irregular = !clk_cfg.tdm_enable &&
      (clk_cfg.bitclk_ratio_sel == CDCFG_R48) &&
      (sample_rate_code == 3'h1 || sample_rate_code == 3'h3 ||
       sample_rate_code == 3'h5 || sample_rate_code == 3'h6);
    // half rate is ignored under tdm, which the host must not combine
    clk_cfg.frame_clock_half_rate = st_r.clk2[CDCFG_P_HALF] &&
                                    !clk_cfg.tdm_enable;
    clk_cfg.clkout_freq_sel =
      cdcfg_clock_output_pin_t'(st_r.clk2[CDCFG_P_CLKOUT_FREQ_SEL +: 3]);
    clk_cfg.clkout_pass_source = (clk_cfg.clkout_freq_sel == CDCFG_CKSRC);
    clk_cfg.bitclk_edge_polarity = st_r.sfmt[CDCFG_P_BITCLK_EDGE_POLARITY];
  end

  // serial format and tdm routing decode
  always_comb begin
    fmt_cfg = '0;
    fmt_cfg.frame_format_sel =
      cdcfg_frame_t'(st_r.sfmt[CDCFG_P_FRM +: 2]);
    fmt_cfg.tdm_source_sel = st_r.sfmt[CDCFG_P_TSRC +: 2];
    // routing only matters under tdm; code 11 flagged as invalid
    if (st_r.sfmt[CDCFG_P_TDM]) begin
      case (fmt_cfg.tdm_source_sel)
        2'b00: begin
          fmt_cfg.din3_from_conv = 1'b0;
          fmt_cfg.din4_from_conv = 1'b0;
        end
        2'b01: begin
          fmt_cfg.din3_from_conv = 1'b0;
          fmt_cfg.din4_from_conv = 1'b1;
        end
        2'b10: begin
          fmt_cfg.din3_from_conv = 1'b1;
          fmt_cfg.din4_from_conv = 1'b1;
        end
        default: fmt_cfg.tdm_source_bad = 1'b1;
      endcase
    end
    fmt_cfg.dsp_in2_format  = cdcfg_fmt2(st_r.dlyf[CDCFG_P_DSP_IN2_FORMAT +: 2]);
    fmt_cfg.dsp_out2_format = cdcfg_fmt2(st_r.dlyf[CDCFG_P_DSP_OUT2_FORMAT +: 2]);
    fmt_cfg.dac_in_format   = cdcfg_fmt2(st_r.demf[CDCFG_P_DAC_IN_FORMAT +: 2]);
    fmt_cfg.dsp_out4_format = cdcfg_fmt2(st_r.dout[CDCFG_P_DSP_OUT4_FORMAT +: 2]);
    fmt_cfg.dsp_out3_format = cdcfg_fmt2(st_r.dout[CDCFG_P_DSP_OUT3_FORMAT +: 2]);
    fmt_cfg.dsp_in1_format  = cdcfg_fmt3(st_r.demf[CDCFG_P_F3 +: 3]);
    fmt_cfg.dsp_out1_format = cdcfg_fmt3(st_r.dout[CDCFG_P_F3 +: 3]);
  end

  // memory partition and accelerator decode
  always_comb begin
    mem_cfg = '0;
    // delay ram: linear n*1024, ring the remainder of 8192
    if (st_r.dlyf[CDCFG_P_BANK +: 4] > CDCFG_BANK_MAX) begin
      mem_cfg.dly_bank_bad = 1'b1;
    end else begin
      mem_cfg.dly_linear_words =
        14'(st_r.dlyf[CDCFG_P_BANK +: 4] * CDCFG_DLY_STEP);
      mem_cfg.dly_ring_words =
        CDCFG_DLY_TOTAL - mem_cfg.dly_linear_words;
    end
    // data ram: bank1 grows by 512 per code step, bank0 the rest
    if (st_r.dram[CDCFG_P_DATA_RAM_SIZE_SEL +: 2] == 2'b11) begin
      mem_cfg.dram_size_bad = 1'b1;
    end else begin
      mem_cfg.dram_bank1_words =
        12'((st_r.dram[CDCFG_P_DATA_RAM_SIZE_SEL +: 2] + 2'b01) * CDCFG_DRAM_STEP);
      mem_cfg.dram_bank0_words =
        CDCFG_DRAM_TOT - mem_cfg.dram_bank1_words;
    end
    mem_cfg.dram_bank1_linear = st_r.dram[CDCFG_P_DADR + 1];
    mem_cfg.dram_bank0_linear = st_r.dram[CDCFG_P_DADR];
    mem_cfg.dly_ptr0_offset   = st_r.dram[CDCFG_P_PTR0];
    // coefficient words are fft points / 4 + 1
    mem_cfg.fft_points = 11'(11'd128 << st_r.dram[CDCFG_P_WAVE +: 2]);
    mem_cfg.coef_ram_words =
      9'((mem_cfg.fft_points >> 2) + 11'd1);
    mem_cfg.accel_ch1_filter_type = st_r.accl[CDCFG_P_FIR1];
    mem_cfg.accel_ch2_filter_type = st_r.accl[CDCFG_P_FIR2];
    mem_cfg.accel_ch1_band_mode   = st_r.accl[CDCFG_P_SUB1];
    mem_cfg.accel_ch2_band_mode   = st_r.accl[CDCFG_P_SUB2];
    // channel 2 takes 0, 256, 512 or 1024; channel 1 the rest
    case (st_r.accl[CDCFG_P_MDIV +: 2])
      2'b00:   mem_cfg.accel_ch2_words = 12'h000;
      2'b01:   mem_cfg.accel_ch2_words = 12'h100;
      2'b10:   mem_cfg.accel_ch2_words = 12'h200;
      default: mem_cfg.accel_ch2_words = 12'h400;
    endcase
    mem_cfg.accel_ch1_words = CDCFG_ACC_TOT - mem_cfg.accel_ch2_words;
    mem_cfg.deemphasis_sel = st_r.demf[CDCFG_P_DEM +: 2];
    mem_cfg.deemphasis_on  = (mem_cfg.deemphasis_sel != 2'b00);
  end

  // jump enables and shared pin direction
  always_comb begin
    jump_cfg.jump_enable = {st_r.accl[CDCFG_P_JX3], st_r.clk2[CDCFG_P_JX2],
                            st_r.sfmt[CDCFG_P_JX1], st_r.sfmt[CDCFG_P_JX0]};
    // a set jump 2 or 3 enable turns its shared pin to an input
    jump_cfg.pin14_out_en = !st_r.clk2[CDCFG_P_JX2] && pin14_sdout3_en;
    jump_cfg.pin15_out_en = !st_r.accl[CDCFG_P_JX3] && pin15_sdout2_en;
  end

  // a clock register write is stored by the next cycle
  property p_clk_write_held;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && hit && pstrb[0] && idx == CDCFG_IDX_CLK2)
      |=> (st_r.clk2 == $past(wb));
  endproperty
  a_clk_write_held: assert property (p_clk_write_held)
    else $error("clock register write not stored");

  property p_tdm_ratio;
    @(posedge pclk) disable iff (!presetn)
      clk_cfg.tdm_enable |-> clk_cfg.bitclk_per_frame == 9'd256;
  endproperty
  a_tdm_ratio: assert property (p_tdm_ratio)
    else $error("tdm did not force 256 bit clocks");

  property p_half_rate;
    @(posedge pclk) disable iff (!presetn)
      clk_cfg.frame_clock_half_rate |-> !clk_cfg.tdm_enable;
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("half rate active under tdm");

  property p_jump_pin;
    @(posedge pclk) disable iff (!presetn)
      jump_cfg.jump_enable[2] |-> !jump_cfg.pin14_out_en;
  endproperty
  a_jump_pin: assert property (p_jump_pin)
    else $error("jump pin still driven");

  property p_clear_start;
    @(posedge pclk) disable iff (!presetn)
      ($rose(st_r.clk2[CDCFG_P_CKRN]) && !st_r.accl[CDCFG_P_ACLR]
       && !accel_clr_we) |=> accel_clr_we && accel_clr_addr == 11'h000;
  endproperty
  a_clear_start: assert property (p_clear_start)
    else $error("coefficient clear did not start");

  property p_clear_len;
    @(posedge pclk) disable iff (!presetn)
      (accel_clr_we && accel_clr_addr == CDCFG_ACC_WORDS) |=> !accel_clr_we;
  endproperty
  a_clear_len: assert property (p_clear_len)
    else $error("coefficient clear overran");

  property p_dly_sum;
    @(posedge pclk) disable iff (!presetn)
      !mem_cfg.dly_bank_bad |->
        mem_cfg.dly_linear_words + mem_cfg.dly_ring_words == CDCFG_DLY_TOTAL;
  endproperty
  a_dly_sum: assert property (p_dly_sum)
    else $error("delay ram split does not total 8192");

  property p_coef_words;
    @(posedge pclk) disable iff (!presetn)
      st_r.dram[1:0] == 2'b11 |-> mem_cfg.coef_ram_words == 9'd257;
  endproperty
  a_coef_words: assert property (p_coef_words)
    else $error("coefficient words wrong for 1024 points");

  property p_bad_fmt;
    @(posedge pclk) disable iff (!presetn)
      st_r.dout[2:1] == 2'b11 |-> fmt_cfg.dsp_out1_format == CDCFG_FBAD;
  endproperty
  a_bad_fmt: assert property (p_bad_fmt)
    else $error("invalid format not flagged");

  property p_ratio_32;
    @(posedge pclk) disable iff (!presetn)
      (!clk_cfg.tdm_enable && clk_cfg.bitclk_ratio_sel == CDCFG_R32)
      |-> clk_cfg.bitclk_per_frame == 9'd32;
  endproperty
  a_ratio_32: assert property (p_ratio_32)
    else $error("ratio code 2 not decoded as 32");

  property p_irregular;
    @(posedge pclk) disable iff (!presetn)
      clk_cfg.bitclk_irregular |->
        clk_cfg.bitclk_ratio_sel == CDCFG_R48 && !clk_cfg.tdm_enable;
  endproperty
  a_irregular: assert property (p_irregular)
    else $error("irregular bit clock outside 48 ratio");

  property p_tdm_src_bad;
    @(posedge pclk) disable iff (!presetn)
      (st_r.sfmt[CDCFG_P_TDM] && st_r.sfmt[CDCFG_P_TSRC +: 2] == 2'b11)
      |-> fmt_cfg.tdm_source_bad && !fmt_cfg.din3_from_conv;
  endproperty
  a_tdm_src_bad: assert property (p_tdm_src_bad)
    else $error("tdm source code 3 not flagged");

  property p_dram_sum;
    @(posedge pclk) disable iff (!presetn)
      !mem_cfg.dram_size_bad |->
        mem_cfg.dram_bank1_words + mem_cfg.dram_bank0_words == CDCFG_DRAM_TOT;
  endproperty
  a_dram_sum: assert property (p_dram_sum)
    else $error("data ram split does not total 2048");

  property p_deemph_on;
    @(posedge pclk) disable iff (!presetn)
      mem_cfg.deemphasis_on == (st_r.demf[CDCFG_P_DEM +: 2] != 2'b00);
  endproperty
  a_deemph_on: assert property (p_deemph_on)
    else $error("de-emphasis enable disagrees with code");

  property p_clear_step;
    @(posedge pclk) disable iff (!presetn)
      (accel_clr_we && accel_clr_addr != CDCFG_ACC_WORDS)
      |=> accel_clr_we && accel_clr_addr == $past(accel_clr_addr) + 11'h001;
  endproperty
  a_clear_step: assert property (p_clear_step)
    else $error("coefficient clear skipped an address");

endmodule

// ### core/cdcfg_pkg.sv
// cdcfg_pkg: offsets, field positions, reset values and decode tables
// for the codec dsp configuration register bank.
// assumes a 32-bit apb slave with one register per aligned word.
package cdcfg_pkg;

  // register indices as printed; byte address is index times four
  localparam logic [7:0] CDCFG_IDX_CLK2 = 8'hC1; // clock_setting_two
  localparam logic [7:0] CDCFG_IDX_SFMT = 8'hC2; // serial_format_jump_setup
  localparam logic [7:0] CDCFG_IDX_DLYF = 8'hC3; // delay_ram_port_format
  localparam logic [7:0] CDCFG_IDX_DRAM = 8'hC4; // data_ram_coef_setup
  localparam logic [7:0] CDCFG_IDX_ACCL = 8'hC5; // accelerator_setup
  localparam logic [7:0] CDCFG_IDX_DEMF = 8'hC6; // deemph_input_format
  localparam logic [7:0] CDCFG_IDX_DOUT = 8'hC7; // dsp_output_format
  // extra status word holding derived decode results
  localparam logic [7:0] CDCFG_IDX_STAT = 8'hC8;
  localparam logic [9:0] CDCFG_ADDR_W   = 10'h000;

  // reset values
  localparam logic [7:0] CDCFG_RST_VAL  = 8'h00;

  // bits that always read zero (reserved "0" positions)
  localparam logic [7:0] CDCFG_MASK_DRAM = 8'hFB;
  localparam logic [7:0] CDCFG_MASK_DEMF = 8'hF7;
  localparam logic [7:0] CDCFG_MASK_DOUT = 8'hF7;

  // field positions, clock_setting_two
  localparam int CDCFG_P_JX2   = 7;
  localparam int CDCFG_P_HALF  = 6;
  localparam int CDCFG_P_RATIO = 4;
  localparam int CDCFG_P_CLKOUT_FREQ_SEL  = 1;
  localparam int CDCFG_P_CKRN  = 0;
  // serial_format_jump_setup
  localparam int CDCFG_P_TDM   = 7;
  localparam int CDCFG_P_BITCLK_EDGE_POLARITY  = 6;
  localparam int CDCFG_P_FRM   = 4;
  localparam int CDCFG_P_TSRC  = 2;
  localparam int CDCFG_P_JX1   = 1;
  localparam int CDCFG_P_JX0   = 0;
  // delay_ram_port_format
  localparam int CDCFG_P_DSP_IN2_FORMAT  = 6;
  localparam int CDCFG_P_DSP_OUT2_FORMAT  = 4;
  localparam int CDCFG_P_BANK  = 0;
  // data_ram_coef_setup
  localparam int CDCFG_P_DATA_RAM_SIZE_SEL  = 6;
  localparam int CDCFG_P_DADR  = 4;
  localparam int CDCFG_P_PTR0  = 3;
  localparam int CDCFG_P_WAVE  = 0;
  // accelerator_setup
  localparam int CDCFG_P_ACLR  = 7;
  localparam int CDCFG_P_JX3   = 6;
  localparam int CDCFG_P_FIR1  = 5;
  localparam int CDCFG_P_FIR2  = 4;
  localparam int CDCFG_P_SUB1  = 3;
  localparam int CDCFG_P_SUB2  = 2;
  localparam int CDCFG_P_MDIV  = 0;
  // deemph_input_format / dsp_output_format
  localparam int CDCFG_P_DEM   = 6;
  localparam int CDCFG_P_DAC_IN_FORMAT = 4;
  localparam int CDCFG_P_F3    = 0;
  localparam int CDCFG_P_DSP_OUT4_FORMAT  = 6;
  localparam int CDCFG_P_DSP_OUT3_FORMAT  = 4;

  // sizes and counts
  localparam logic [13:0] CDCFG_DLY_TOTAL = 14'h2000; // 8192 words
  localparam logic [13:0] CDCFG_DLY_STEP  = 14'h0400; // 1024 words
  localparam logic [3:0]  CDCFG_BANK_MAX  = 4'h8;
  localparam logic [11:0] CDCFG_DRAM_STEP = 12'h200;  // 512 words
  localparam logic [11:0] CDCFG_DRAM_TOT  = 12'h800;  // 2048 words
  localparam logic [11:0] CDCFG_ACC_TOT   = 12'h800;  // 2048 words
  localparam logic [2:0]  CDCFG_DFS_48K   = 3'h5;
  localparam logic [10:0] CDCFG_ACC_WORDS = 11'h7FF;  // clear sweep top

  // encodings
  typedef enum logic [1:0] {
    CDCFG_R64 = 2'b00, CDCFG_R48 = 2'b01, CDCFG_R32 = 2'b10, CDCFG_R256 = 2'b11
  } cdcfg_ratio_t;
  typedef enum logic [1:0] {
    CDCFG_FSTD = 2'b00, CDCFG_FI2S = 2'b01,
    CDCFG_FPCMS = 2'b10, CDCFG_FPCML = 2'b11
  } cdcfg_frame_t;
  typedef enum logic [2:0] {
    CDCFG_MSB24 = 3'h0, CDCFG_LSB24 = 3'h1, CDCFG_LSB20 = 3'h2,
    CDCFG_LSB16 = 3'h3, CDCFG_MULAW = 3'h4, CDCFG_ALAW  = 3'h5,
    CDCFG_FBAD  = 3'h6
  } cdcfg_fmt_t;
  typedef enum logic [2:0] {
    CDCFG_CK12M = 3'h0, CDCFG_CK6M = 3'h1, CDCFG_CK3M = 3'h2,
    CDCFG_CK8M  = 3'h3, CDCFG_CK4M = 3'h4, CDCFG_CK2M = 3'h5,
    CDCFG_CK256 = 3'h6, CDCFG_CKSRC = 3'h7
  } cdcfg_clock_output_pin_t;

  // clock generator controls
  typedef struct packed {
    logic         clock_reset_n;       // 0 holds generator in reset
    cdcfg_ratio_t bitclk_ratio_sel;
    logic [8:0]   bitclk_per_frame;    // 64, 48, 32 or 256
    logic         bitclk_irregular;    // 48 per frame, four rate codes
    logic         frame_clock_half_rate;
    cdcfg_clock_output_pin_t  clkout_freq_sel;
    logic         clkout_pass_source;  // crystal_input or bit_clock
    logic         bitclk_edge_polarity; // 1 rising, 0 falling
    logic         tdm_enable;
  } cdcfg_clk_t;

  // serial port formats
  typedef struct packed {
    cdcfg_frame_t frame_format_sel;
    logic [1:0]   tdm_source_sel;
    logic         tdm_source_bad;
    logic         din3_from_conv;     // dsp input 3 from converter
    logic         din4_from_conv;     // dsp input 4 from converter
    cdcfg_fmt_t   dsp_in1_format;
    cdcfg_fmt_t   dsp_in2_format;
    cdcfg_fmt_t   dsp_out1_format;
    cdcfg_fmt_t   dsp_out2_format;
    cdcfg_fmt_t   dsp_out3_format;
    cdcfg_fmt_t   dsp_out4_format;
    cdcfg_fmt_t   dac_in_format;
  } cdcfg_fmt_bus_t;

  // memory and accelerator controls
  typedef struct packed {
    logic [13:0] dly_linear_words;
    logic [13:0] dly_ring_words;
    logic        dly_bank_bad;
    logic [11:0] dram_bank1_words;
    logic [11:0] dram_bank0_words;
    logic        dram_size_bad;
    logic        dram_bank1_linear;
    logic        dram_bank0_linear;
    logic        dly_ptr0_offset;
    logic [8:0]  coef_ram_words;      // 33, 65, 129, 257
    logic [10:0] fft_points;          // 128 .. 1024
    logic        accel_ch1_filter_type;
    logic        accel_ch2_filter_type;
    logic        accel_ch1_band_mode;
    logic        accel_ch2_band_mode;
    logic [11:0] accel_ch1_words;
    logic [11:0] accel_ch2_words;
    logic [1:0]  deemphasis_sel;      // 0 off, 48k, 44.1k, 32k
    logic        deemphasis_on;
  } cdcfg_mem_t;

  // jump pin routing
  typedef struct packed {
    logic [3:0] jump_enable;          // jumps 3..0 armed
    logic       pin14_out_en;         // serial out 3 drives pin
    logic       pin15_out_en;         // serial out 2 drives pin
  } cdcfg_jump_t;

  // all module state
  typedef struct packed {
    logic [7:0]  clk2;
    logic [7:0]  sfmt;
    logic [7:0]  dlyf;
    logic [7:0]  dram;
    logic [7:0]  accl;
    logic [7:0]  demf;
    logic [7:0]  dout;
    logic        clr_busy;            // zero fill in progress
    logic [10:0] clr_addr;
    logic        ckrst_d;             // last clock reset level
    logic        pslverr;
    logic [31:0] prdata;
  } cdcfg_state_t;

  // widen a two-bit format code to the common three-bit encoding
  function automatic cdcfg_fmt_t cdcfg_fmt2(input logic [1:0] c);
    return cdcfg_fmt_t'({1'b0, c});
  endfunction

  // three-bit format code; 110 and 111 fold to the invalid marker
  function automatic cdcfg_fmt_t cdcfg_fmt3(input logic [2:0] c);
    return (c > 3'h5) ? CDCFG_FBAD : cdcfg_fmt_t'(c);
  endfunction

endpackage

// ### testbench/cdcfg_host.sv
// cdcfg_host: apb host that programs the codec dsp register bank.
// assumes tb_top holds miscompares and give_verdict.
`timescale 1ns/1ps
module cdcfg_host
  import cdcfg_pkg::*;
(
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  // bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end

  // one transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      tb_top.miscompares++;
      $display("[FAIL] t=%0t apb wait timed out", $time);
      tb_top.give_verdict();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines stop showing old values
    paddr <= ~a;
    pwdata <= ~d;
    #1;
  endtask
endmodule

// ### testbench/tb_top.sv
// tb_top: register bank bench, host model plus decode checks.
// assumes a free-running pclk and host programming inside resets.
`timescale 1ns/1ps
module tb_top
  import cdcfg_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic sysrst_n, p14_en, p15_en, clr_we;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [2:0] rate;
  logic [10:0] clr_addr;
  cdcfg_clk_t clk_cfg;
  cdcfg_fmt_bus_t fmt_cfg;
  cdcfg_mem_t mem_cfg;
  cdcfg_jump_t jump_cfg;
  int miscompares = 0;
  int num_checks = 0;
  logic [7:0] msk [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFB, 8'hFF, 8'hF7, 8'hF7};
  logic [7:0] ini [7] = '{8'hBE, 8'hCF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [31:0] rt [4] = '{64, 48, 32, 256};
  logic [31:0] acc [4] = '{2048, 1792, 1536, 1024};

  always #2 pclk = ~pclk;

  cdcfg_host host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));

  cdcfg_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sample_rate_code(rate), .system_reset_n(sysrst_n),
    .pin14_sdout3_en(p14_en), .pin15_sdout2_en(p15_en),
    .clk_cfg(clk_cfg), .fmt_cfg(fmt_cfg), .mem_cfg(mem_cfg),
    .jump_cfg(jump_cfg), .accel_clr_we(clr_we), .accel_clr_addr(clr_addr));

  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h expected %h", $time, g, x);
    end
  endtask

  // register write and read-compare by index
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    host.xfer(1'b1, {2'b00, i, 2'b00}, {24'h0, v}, q, e);
  endtask
  task automatic rdc(input logic [7:0] i, input logic [7:0] x);
    host.xfer(1'b0, {2'b00, i, 2'b00}, 32'h0, q, e);
    chk(q, {24'h0, x});
  endtask

  // single end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    int c;
    int n;
    pclk = 1'b0;
    presetn = 1'b0;
    rate = 3'h0;
    sysrst_n = 1'b0;
    p14_en = 1'b1;
    p15_en = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (c = 0; c < 7; c++) rdc(8'hC1 + 8'(c), 8'h00);
    chk(32'(clk_cfg.clock_reset_n), 32'h0);
    $display("test reset values done");
    // near all ones; half rate off beside tdm, framing kept standard
    for (c = 0; c < 7; c++) begin
      wr(8'hC1 + 8'(c), ini[c]);
      rdc(8'hC1 + 8'(c), ini[c] & msk[c]);
    end
    chk(32'(fmt_cfg.dsp_in1_format), 32'(CDCFG_FBAD));
    chk(32'(fmt_cfg.dac_in_format), 32'h3);
    chk(32'(jump_cfg.jump_enable), 32'hF);
    chk(32'({jump_cfg.pin14_out_en, jump_cfg.pin15_out_en}), 32'h0);
    wr(8'hC1, 8'h3E);
    wr(8'hC5, 8'hBF);
    chk(32'(jump_cfg.jump_enable), 32'h3);
    chk(32'({jump_cfg.pin14_out_en, jump_cfg.pin15_out_en}), 32'h3);
    host.xfer(1'b0, 12'h300, 32'h0, q, e);
    chk(32'(e), 32'h1);
    wr(8'hC6, 8'h33);
    wr(8'hC7, 8'hF3);
    $display("test access and jumps done");
    wr(8'hC2, 8'h00);
    for (c = 0; c < 4; c++) begin
      wr(8'hC1, 8'(c << 4));
      chk(32'(clk_cfg.bitclk_per_frame), rt[c]);
    end
    wr(8'hC1, 8'h10);
    for (c = 0; c < 7; c++) begin
      @(posedge pclk);
      rate <= 3'(c);
      @(posedge pclk);
      #1;
      chk(32'(clk_cfg.bitclk_irregular), 32'(c % 2 == 1 || c == 6));
    end
    for (c = 0; c < 8; c++) begin
      wr(8'hC1, 8'(c << 1));
      chk(32'(clk_cfg.clkout_freq_sel), 32'(c));
      chk(32'(clk_cfg.clkout_pass_source), 32'(c == 7));
    end
    $display("test clocking done");
    for (c = 0; c < 10; c++) begin
      wr(8'hC3, 8'(c));
      chk(32'(mem_cfg.dly_bank_bad), 32'(c > 8));
      if (c < 9) begin
        chk(32'(mem_cfg.dly_linear_words), 32'(c * 1024));
        chk(32'(mem_cfg.dly_ring_words), 32'(8192 - c * 1024));
      end
    end
    for (c = 0; c < 4; c++) begin
      wr(8'hC4, 8'(c * 8'h51));
      chk(32'(mem_cfg.dram_size_bad), 32'(c == 3));
      if (c < 3)
        chk(32'(mem_cfg.dram_bank1_words), 32'((c + 1) * 512));
      if (c < 3)
        chk(32'(mem_cfg.dram_bank0_words), 32'(1536 - c * 512));
      chk(32'({mem_cfg.dram_bank1_linear, mem_cfg.dram_bank0_linear}),
        32'(c));
      chk(32'(mem_cfg.coef_ram_words), 32'((32 << c) + 1));
      chk(32'(mem_cfg.fft_points), 32'(128 << c));
      wr(8'hC5, 8'(8'h80 | c * 8'h15));
      chk(32'({mem_cfg.accel_ch1_filter_type,
        mem_cfg.accel_ch2_filter_type}), 32'(c));
      chk(32'({mem_cfg.accel_ch1_band_mode,
        mem_cfg.accel_ch2_band_mode}), 32'(c));
      chk(32'(mem_cfg.accel_ch1_words), acc[c]);
      chk(32'(mem_cfg.accel_ch2_words), 2048 - acc[c]);
    end
    wr(8'hC8, 8'hFF);
    rdc(8'hC8, 8'h06);
    $display("test memory done");
    @(posedge pclk);
    rate <= 3'h2;
    wr(8'hC1, 8'h30);
    wr(8'hC3, 8'h00);
    wr(8'hC7, 8'h00);
    for (c = 0; c < 4; c++) begin
      wr(8'hC2, 8'(8'h80 | c * 8'h14 | (c % 2) * 8'h40));
      chk(32'(clk_cfg.tdm_enable), 32'h1);
      chk(32'(clk_cfg.bitclk_edge_polarity), 32'(c % 2));
      chk(32'(fmt_cfg.frame_format_sel), 32'(c));
      chk(32'(fmt_cfg.tdm_source_bad), 32'(c == 3));
      chk(32'({fmt_cfg.din3_from_conv, fmt_cfg.din4_from_conv}),
        32'({c == 2, c == 1 || c == 2}));
      wr(8'hC6, 8'(c << 6));
      chk(32'({mem_cfg.deemphasis_on, mem_cfg.deemphasis_sel}),
        32'({c != 0, 2'(c)}));
    end
    $display("test serial formats done");
    wr(8'hC2, 8'h00);
    wr(8'hC5, 8'h00);
    wr(8'hC1, 8'h01);
    n = 0;
    while (clr_we !== 1'b1 && n < 4) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(32'(clr_we), 32'h1);
    chk(32'(clr_addr), 32'h0);
    n = 0;
    while (clr_we === 1'b1 && n < 3000) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(32'(n), 32'd2048);
    chk(32'(clk_cfg.clock_reset_n), 32'h1);
    wr(8'hC1, 8'h00);
    wr(8'hC5, 8'h80);
    wr(8'hC1, 8'h01);
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(clr_we), 32'h0);
    $display("test coefficient clear done");
    give_verdict();
  end
endmodule
